// File: hdl/ibreg_cfg.svh
`ifndef IBREG_CFG_SVH
`define IBREG_CFG_SVH
// address codes (addr_bit1, addr_bit0)
`define IBREG_ADDR_STATE 2'h0
`define IBREG_ADDR_CMD 2'h1
`define IBREG_ADDR_CAUSE 2'h2
`define IBREG_ADDR_DATA 2'h3
`define IBREG_ADDR_NONE 2'h0
`define IBREG_ADDR_CTRL 2'h1
`define IBREG_ADDR_POLL 2'h2
`define IBREG_ADDR_OUT 2'h3
// state flag positions
`define IBREG_ST_LISTEN 0
`define IBREG_ST_TALK 1
`define IBREG_ST_POLL 2
`define IBREG_ST_REMOTE 3
`define IBREG_ST_SRQ 4
// cause bits
`define IBREG_IC_CMD 0
`define IBREG_IC_OUT_EMPTY 1
`define IBREG_IC_DATA 2
// control bits, active low pulses
`define IBREG_CT_PWRUP 2
`define IBREG_CT_LOCAL 10
`define IBREG_CT_EOI 12
`define IBREG_CT_WIDTH 16
// status byte fields
`define IBREG_PS_SRQ 7
`define IBREG_PS_DONE 5
`define IBREG_PS_SRQ_DONE 8'h50
`define IBREG_CT_RESET 16'hFFFF
`define IBREG_BYTE_RESET 8'h00
`endif

// File: hdl/ibreg_pkg.sv
package ibreg_pkg;
  typedef logic [7:0] ibreg_byte_t;
  typedef enum logic [2:0] {
    IBREG_RD_STATE = 3'b000,
    IBREG_RD_CMD = 3'b001,
    IBREG_RD_CAUSE = 3'b010,
    IBREG_RD_DATA = 3'b011,
    IBREG_WR_NONE = 3'b100,
    IBREG_WR_CTRL = 3'b101,
    IBREG_WR_POLL = 3'b110,
    IBREG_WR_OUT = 3'b111
  } ibreg_sel_t;
endpackage

// File: hdl/ibreg_if.sv
`timescale 1ns/100ps
interface ibreg_if;
  logic phi2;
  logic interface_select_n;
  logic read_write_n;
  logic addr_bit1_n;
  logic addr_bit0_n;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic interrupt_request_n;
  modport dev (
    input phi2, interface_select_n, read_write_n, addr_bit1_n, addr_bit0_n, wdata,
    output rdata, interrupt_request_n
  );
  modport cpu (
    output phi2, interface_select_n, read_write_n, addr_bit1_n, addr_bit0_n, wdata,
    input rdata, interrupt_request_n
  );
endinterface

// File: hdl/ibreg_dev.sv
`timescale 1ns/100ps
`include "ibreg_cfg.svh"
// Overview of operation
// (R1) select only when selected low and phase two
// (R2) rw and two address bits pick strobe
// (R3) reads: state, command, cause, received data
// (R4) writes: none, control, poll status, outgoing
// (R5) state read shows listen talk poll remote srq
// (R6) processor reads command after a command
// (R7) interrupt asserted, cause buffer shows reason
// (R8) received byte latched, data flag, interrupt raised
// (R9) cause bit 2 high when data waits
// (R10) control bit 10 pulse clears remote
// (R11) control bit 2 pulse clears poll talk listen
// (R12) control bit 12 low asserts eoi after last
// (R13) poll status byte supplied in poll mode
// (R14) outgoing data one byte per write
// (R15) outgoing data drives only outside poll mode
// (R16) cause read clears interrupt flag
// (R17) received data read clears data flag
// (R18) write to code zero has no effect
module ibreg_dev
  import ibreg_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  // processor side
  ibreg_if.dev bus,
  // bus engine side
  input wire logic set_listen,
  input wire logic set_talk,
  input wire logic set_poll,
  input wire logic clr_poll,
  input wire logic set_remote,
  input wire logic set_srq,
  input wire logic byte_in_valid,
  input wire logic [7:0] byte_in,
  input wire logic cmd_in_valid,
  input wire logic [7:0] cmd_in,
  input wire logic out_taken,
  output logic [7:0] bus_byte_out,
  output logic bus_byte_out_en,
  output logic eoi_request,
  output logic out_pending
);
  // processor lines cross in from another clock; two flops first
  logic [4:0] sync1, sync2;
  logic [7:0] wd1, wd2;
  logic phi2_d;
  logic [7:0] state_flags, cmd_reg, data_reg, poll_reg, out_reg;
  logic [15:0] ctrl_reg;
  logic irq_flag, cmd_flag, data_flag;
  logic [7:0] rdata_q;
  logic irq_n_q;
  logic [7:0] next_state_flags, next_cmd_reg, next_data_reg, next_poll_reg, next_out_reg;
  logic [15:0] next_ctrl_reg;
  logic next_irq_flag, next_cmd_flag, next_data_flag, next_out_pending;
  logic [7:0] next_rdata;
  logic [7:0] next_bus_byte_out;
  logic next_bus_byte_out_en, next_eoi_request, next_irq_n;
  logic strobe;
  ibreg_sel_t sel;
  logic [7:0] cause;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync1 <= 5'h0F;
      sync2 <= 5'h0F;
      wd1 <= 8'h00;
      wd2 <= 8'h00;
      phi2_d <= 1'b0;
    end else begin
      sync1 <= {bus.phi2, bus.interface_select_n, bus.read_write_n,
                bus.addr_bit1_n, bus.addr_bit0_n};
      sync2 <= sync1;
      wd1 <= bus.wdata;
      wd2 <= wd1;
      phi2_d <= sync2[4];
    end
  end

  // one access per rising phase two while selected
  assign strobe = sync2[4] && !phi2_d && !sync2[3]; // [R1]
  // address lines are active low, so invert to get the code; rw high means write
  assign sel = ibreg_sel_t'({sync2[2], !sync2[1], !sync2[0]}); // [R2]
  assign cause = {5'h00, data_flag, !out_pending, cmd_flag}; // [R7] [R9]

  always_comb begin
    next_state_flags = state_flags;
    next_cmd_reg = cmd_reg;
    next_data_reg = data_reg;
    next_poll_reg = poll_reg;
    next_out_reg = out_reg;
    next_ctrl_reg = ctrl_reg;
    next_irq_flag = irq_flag;
    next_cmd_flag = cmd_flag;
    next_data_flag = data_flag;
    next_out_pending = out_pending;
    next_rdata = rdata_q;
    if (out_taken) begin
      next_out_pending = 1'b0;
    end
    if (strobe) begin
      case (sel)
        IBREG_RD_STATE: next_rdata = state_flags; // [R5] [R3]
        IBREG_RD_CMD: begin
          next_rdata = cmd_reg; // [R6]
          next_cmd_flag = 1'b0;
        end
        IBREG_RD_CAUSE: begin
          next_rdata = cause;
          next_irq_flag = 1'b0; // [R16]
        end
        IBREG_RD_DATA: begin
          next_rdata = data_reg;
          next_data_flag = 1'b0; // [R17]
        end
        IBREG_WR_NONE: next_rdata = rdata_q; // [R18] [R4]
        // byte-wide bus: upper half takes the byte nibble-swapped, so bits 2, 10, 12 differ
        IBREG_WR_CTRL: next_ctrl_reg = {wd2[3:0], wd2[7:4], wd2}; // [R10] [R12]
        IBREG_WR_POLL: next_poll_reg = wd2; // [R13]
        IBREG_WR_OUT: begin
          next_out_reg = wd2; // [R14]
          next_out_pending = 1'b1;
        end
        default: next_rdata = rdata_q;
      endcase
    end
    // control pulses: act on the low level of the written bit
    if (!ctrl_reg[`IBREG_CT_LOCAL]) begin
      next_state_flags[`IBREG_ST_REMOTE] = 1'b0; // [R10]
    end
    if (!ctrl_reg[`IBREG_CT_PWRUP]) begin
      next_state_flags[`IBREG_ST_POLL] = 1'b0; // [R11]
      next_state_flags[`IBREG_ST_TALK] = 1'b0;
      next_state_flags[`IBREG_ST_LISTEN] = 1'b0;
    end
    // engine events win over clears in the same cycle
    if (set_listen) begin
      next_state_flags[`IBREG_ST_LISTEN] = 1'b1;
    end
    if (set_talk) begin
      next_state_flags[`IBREG_ST_TALK] = 1'b1;
    end
    if (clr_poll) begin
      next_state_flags[`IBREG_ST_POLL] = 1'b0;
    end
    if (set_poll) begin
      next_state_flags[`IBREG_ST_POLL] = 1'b1;
    end
    if (set_remote) begin
      next_state_flags[`IBREG_ST_REMOTE] = 1'b1;
    end
    next_state_flags[`IBREG_ST_SRQ] = state_flags[`IBREG_ST_SRQ] | set_srq;
    if (byte_in_valid) begin
      next_data_reg = byte_in; // [R8]
      next_data_flag = 1'b1;
      next_irq_flag = 1'b1;
    end
    if (cmd_in_valid) begin
      next_cmd_reg = cmd_in;
      next_cmd_flag = 1'b1;
      next_irq_flag = 1'b1;
    end
    // poll mode presents the status byte instead of data
    next_bus_byte_out = next_state_flags[`IBREG_ST_POLL] ? next_poll_reg : next_out_reg; // [R15]
    next_bus_byte_out_en = !next_state_flags[`IBREG_ST_POLL]; // [R15]
    next_eoi_request = !next_ctrl_reg[`IBREG_CT_EOI]; // [R12]
    next_irq_n = !next_irq_flag; // [R7]
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_flags <= `IBREG_BYTE_RESET;
      cmd_reg <= `IBREG_BYTE_RESET;
      data_reg <= `IBREG_BYTE_RESET;
      poll_reg <= `IBREG_BYTE_RESET;
      out_reg <= `IBREG_BYTE_RESET;
      ctrl_reg <= `IBREG_CT_RESET;
      irq_flag <= 1'b0;
      cmd_flag <= 1'b0;
      data_flag <= 1'b0;
      out_pending <= 1'b0;
      rdata_q <= `IBREG_BYTE_RESET;
      irq_n_q <= 1'b1;
      bus_byte_out <= `IBREG_BYTE_RESET;
      bus_byte_out_en <= 1'b0;
      eoi_request <= 1'b0;
    end else begin
      state_flags <= next_state_flags;
      cmd_reg <= next_cmd_reg;
      data_reg <= next_data_reg;
      poll_reg <= next_poll_reg;
      out_reg <= next_out_reg;
      ctrl_reg <= next_ctrl_reg;
      irq_flag <= next_irq_flag;
      cmd_flag <= next_cmd_flag;
      data_flag <= next_data_flag;
      out_pending <= next_out_pending;
      rdata_q <= next_rdata;
      irq_n_q <= next_irq_n;
      bus_byte_out <= next_bus_byte_out;
      bus_byte_out_en <= next_bus_byte_out_en;
      eoi_request <= next_eoi_request;
    end
  end

  assign bus.rdata = rdata_q;
  assign bus.interrupt_request_n = irq_n_q;
endmodule

// File: hdl/ibreg_cpu.sv
`timescale 1ns/100ps
`include "ibreg_cfg.svh"
module ibreg_cpu
  import ibreg_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  // user request
  input wire logic req,
  input wire logic req_write,
  input wire logic [1:0] req_addr,
  input wire logic [7:0] req_wdata,
  output logic busy,
  output logic [7:0] rd_data,
  output logic rd_valid,
  output logic irq_seen,
  // device side
  ibreg_if.cpu bus
);
  typedef enum logic [1:0] {
    IBREG_IDLE = 2'b00,
    IBREG_SETUP = 2'b01,
    IBREG_HIGH = 2'b10,
    IBREG_DONE = 2'b11
  } ibreg_cpu_st_t;
  // phase two held long enough for the device synchroniser
  localparam logic [2:0] PHASE_CYCLES = 3'h6;
  ibreg_cpu_st_t st, next_st;
  logic [2:0] cnt, next_cnt;
  logic wr_q, next_wr_q;
  logic [1:0] addr_q, next_addr_q;
  logic [7:0] wd_q, next_wd_q, next_rd_data;
  logic phi2_q, next_phi2, sel_n_q, next_sel_n, next_rd_valid;
  logic irq1, irq2;

  always_comb begin
    next_st = st;
    next_cnt = cnt;
    next_wr_q = wr_q;
    next_addr_q = addr_q;
    next_wd_q = wd_q;
    next_phi2 = phi2_q;
    next_sel_n = sel_n_q;
    next_rd_data = rd_data;
    next_rd_valid = 1'b0;
    case (st)
      IBREG_IDLE: begin
        if (req) begin
          next_wr_q = req_write;
          next_addr_q = req_addr;
          next_wd_q = req_wdata;
          next_sel_n = 1'b0; // [R1]
          next_cnt = PHASE_CYCLES;
          next_st = IBREG_SETUP;
        end
      end
      IBREG_SETUP: begin
        next_cnt = cnt - 3'h1;
        if (cnt == 3'h1) begin
          next_phi2 = 1'b1;
          next_cnt = PHASE_CYCLES;
          next_st = IBREG_HIGH;
        end
      end
      IBREG_HIGH: begin
        next_cnt = cnt - 3'h1;
        if (cnt == 3'h1) begin
          next_phi2 = 1'b0;
          next_sel_n = 1'b1;
          next_st = IBREG_DONE;
        end
      end
      IBREG_DONE: begin
        next_rd_data = bus.rdata; // [R7]
        next_rd_valid = !wr_q;
        next_st = IBREG_IDLE;
      end
      default: next_st = IBREG_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st <= IBREG_IDLE;
      cnt <= 3'h0;
      wr_q <= 1'b0;
      addr_q <= 2'h0;
      wd_q <= 8'h00;
      phi2_q <= 1'b0;
      sel_n_q <= 1'b1;
      rd_data <= 8'h00;
      rd_valid <= 1'b0;
      busy <= 1'b0;
      irq1 <= 1'b1;
      irq2 <= 1'b1;
      irq_seen <= 1'b0;
    end else begin
      st <= next_st;
      cnt <= next_cnt;
      wr_q <= next_wr_q;
      addr_q <= next_addr_q;
      wd_q <= next_wd_q;
      phi2_q <= next_phi2;
      sel_n_q <= next_sel_n;
      rd_data <= next_rd_data;
      rd_valid <= next_rd_valid;
      busy <= (next_st != IBREG_IDLE);
      irq1 <= bus.interrupt_request_n;
      irq2 <= irq1;
      irq_seen <= !irq2;
    end
  end

  assign bus.phi2 = phi2_q;
  assign bus.interface_select_n = sel_n_q;
  assign bus.read_write_n = wr_q; // [R2]
  assign bus.addr_bit1_n = !addr_q[1];
  assign bus.addr_bit0_n = !addr_q[0];
  assign bus.wdata = wd_q; // [R14]
endmodule

// File: test/ibreg_monitor.sv
`timescale 1ns/100ps
module ibreg_monitor (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // interface signals
  input wire logic phi2,
  input wire logic interface_select_n,
  input wire logic read_write_n,
  input wire logic addr_bit1_n,
  input wire logic addr_bit0_n,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic interrupt_request_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic rd_cause;
  assign rd_cause = !interface_select_n && !read_write_n && !addr_bit1_n && addr_bit0_n;
  sequence s_setup;
    !phi2 [*6] ##1 phi2;
  endsequence
  sequence s_high;
    phi2 [*6] ##1 !phi2;
  endsequence
  property p_setup;
    $fell(interface_select_n) |-> s_setup;
  endproperty
  property p_high;
    $rose(phi2) |-> s_high;
  endproperty
  property p_sel_phi2;
    phi2 |-> !interface_select_n;
  endproperty
  property p_release;
    $fell(phi2) |-> interface_select_n;
  endproperty
  property p_addr_stable;
    !interface_select_n && !$fell(interface_select_n)
      |-> $stable({read_write_n, addr_bit1_n, addr_bit0_n});
  endproperty
  property p_wdata_stable;
    !interface_select_n && !$fell(interface_select_n) && read_write_n |-> $stable(wdata);
  endproperty
  property p_rdata_read;
    $changed(rdata) |-> !interface_select_n && !read_write_n;
  endproperty
  property p_irq_release;
    $rose(interrupt_request_n) |-> rd_cause;
  endproperty
  a_setup: assert property (p_setup) else $error("select setup wrong");
  a_high: assert property (p_high) else $error("phase two width wrong");
  a_sel_phi2: assert property (p_sel_phi2) else $error("phase two unselected");
  a_release: assert property (p_release) else $error("select held");
  a_addr_stable: assert property (p_addr_stable) else $error("code moved");
  a_wdata_stable: assert property (p_wdata_stable) else $error("wdata moved");
  a_rdata_read: assert property (p_rdata_read) else $error("rdata outside read");
  a_irq_release: assert property (p_irq_release) else $error("irq freed");
  c_irq_release: cover property ($rose(interrupt_request_n));
endmodule

// File: test/instrument_bus_interface_regs_test.sv
`timescale 1ns/100ps
module instrument_bus_interface_regs_test;
  import ibreg_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic req = 1'b0;
  logic req_write = 1'b0;
  logic [1:0] req_addr = 2'h0;
  ibreg_byte_t req_wdata = 8'h00;
  ibreg_byte_t byte_in = 8'h00;
  ibreg_byte_t cmd_in = 8'h00;
  // listen talk poll remote srq clr_poll byte cmd taken
  logic [8:0] ev = 9'h000;
  logic busy, rd_valid, irq_seen, bus_byte_out_en, eoi_request, out_pending;
  ibreg_byte_t rd_data, bus_byte_out, st, v;
  logic [4:0] m;
  int n_mismatch = 0;
  int checks = 0;
  int cycles = 0;
  ibreg_byte_t exp_q[$];
  ibreg_if bus_if ();
  ibreg_dev u_ibreg_dev (.clk(clk), .rst(rst), .bus(bus_if.dev), .set_listen(ev[0]),
    .set_talk(ev[1]), .set_poll(ev[2]), .set_remote(ev[3]), .set_srq(ev[4]),
    .clr_poll(ev[5]), .byte_in_valid(ev[6]), .byte_in(byte_in), .cmd_in_valid(ev[7]),
    .cmd_in(cmd_in), .out_taken(ev[8]), .bus_byte_out(bus_byte_out),
    .bus_byte_out_en(bus_byte_out_en), .eoi_request(eoi_request), .out_pending(out_pending));
  ibreg_cpu u_ibreg_cpu (.clk(clk), .rst(rst), .req(req), .req_write(req_write),
    .req_addr(req_addr), .req_wdata(req_wdata), .busy(busy), .rd_data(rd_data),
    .rd_valid(rd_valid), .irq_seen(irq_seen), .bus(bus_if.cpu));
  ibreg_monitor u_ibreg_monitor (.clk(clk), .rst(rst), .phi2(bus_if.phi2),
    .interface_select_n(bus_if.interface_select_n), .read_write_n(bus_if.read_write_n),
    .addr_bit1_n(bus_if.addr_bit1_n), .addr_bit0_n(bus_if.addr_bit0_n),
    .wdata(bus_if.wdata), .rdata(bus_if.rdata),
    .interrupt_request_n(bus_if.interrupt_request_n));
  initial begin
    forever #10 clk = ~clk;
  end
  task automatic test_done();
    if (n_mismatch == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic acc(input logic wr, input logic [1:0] a, input ibreg_byte_t d);
    @(posedge clk);
    req <= 1'b1;
    req_write <= wr;
    req_addr <= a;
    req_wdata <= d;
    @(posedge clk);
    req <= 1'b0;
    @(posedge clk);
    while (busy !== 1'b0) @(posedge clk);
  endtask
  task automatic rd(input logic [1:0] a, input ibreg_byte_t e);
    exp_q.push_back(e);
    acc(1'b0, a, 8'h00);
  endtask
  task automatic pulse(input logic [8:0] p);
    @(posedge clk);
    ev <= p;
    @(posedge clk);
    ev <= 9'h000;
    repeat (4) @(posedge clk);
  endtask
  // reads only: a write never strobes rd_valid
  always @(posedge clk) begin
    if (rd_valid === 1'b1 && exp_q.size() > 0) cmp(rd_data, exp_q.pop_front());
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles > 20000) begin
      n_mismatch++;
      test_done();
    end
  end
  initial begin
    void'($urandom(47767));
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    rd(2'h0, 8'h00);
    rd(2'h2, 8'h02);
    st = 8'h00;
    for (int i = 0; i < 4; i++) begin
      m = 5'($urandom);
      pulse({4'h0, m});
      st = st | {3'h0, m};
      rd(2'h0, st);
      cmp({7'h00, bus_byte_out_en}, {7'h00, !st[2]});
      acc(1'b1, 2'h1, 8'hFB);
      acc(1'b1, 2'h1, 8'hFF);
      st = st & 8'h18;
      rd(2'h0, st);
    end
    cmp({7'h00, eoi_request}, 8'h00);
    acc(1'b1, 2'h1, 8'hFE);
    cmp({7'h00, eoi_request}, 8'h01);
    acc(1'b1, 2'h1, 8'hFF);
    cmp({7'h00, eoi_request}, 8'h00);
    pulse(9'h008);
    st = st | 8'h08;
    rd(2'h0, st);
    acc(1'b1, 2'h1, 8'hBF);
    acc(1'b1, 2'h1, 8'hFF);
    st = st & 8'hF7;
    rd(2'h0, st);
    v = 8'($urandom);
    cmd_in <= v;
    pulse(9'h080);
    cmp({7'h00, bus_if.interrupt_request_n}, 8'h00);
    cmp({7'h00, irq_seen}, 8'h01);
    rd(2'h2, 8'h03);
    cmp({7'h00, bus_if.interrupt_request_n}, 8'h01);
    rd(2'h1, v);
    rd(2'h2, 8'h02);
    v = 8'($urandom);
    byte_in <= v;
    pulse(9'h040);
    cmp({7'h00, bus_if.interrupt_request_n}, 8'h00);
    rd(2'h2, 8'h06);
    rd(2'h3, v);
    rd(2'h2, 8'h02);
    v = 8'($urandom);
    acc(1'b1, 2'h3, v);
    cmp(bus_byte_out, v);
    cmp({7'h00, out_pending}, 8'h01);
    rd(2'h2, 8'h00);
    pulse(9'h100);
    cmp({7'h00, out_pending}, 8'h00);
    acc(1'b1, 2'h0, 8'h00);
    rd(2'h0, st);
    rd(2'h2, 8'h02);
    pulse(9'h004);
    acc(1'b1, 2'h2, 8'h50);
    cmp(bus_byte_out, 8'h50);
    cmp({7'h00, bus_byte_out_en}, 8'h00);
    pulse(9'h020);
    cmp({7'h00, bus_byte_out_en}, 8'h01);
    rd(2'h0, st);
    repeat (20) @(posedge clk);
    cmp(8'(exp_q.size()), 8'h00);
    test_done();
  end
endmodule
